// [hw/esfc_defs.svh]
// Purpose: Offsets, field positions, reset values and timing values in ns for the sensor front end
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Definitions only
`ifndef ESFC_DEFS_SVH
`define ESFC_DEFS_SVH
`define ESFC_OFF_PARAM 12'h000
`define ESFC_OFF_CAL 12'h004
`define ESFC_OFF_CTRL 12'h008
`define ESFC_OFF_STATUS 12'h00C
`define ESFC_RANG_LSB 0
`define ESFC_SETI_LSB 5
`define ESFC_T1_LSB 10
`define ESFC_T2_BIT 12
`define ESFC_PRESET_BIT 13
`define ESFC_LSEL_LSB 14
`define ESFC_PARAM_RST 32'h00000000
`define ESFC_CAL_SW_BIT 0
`define ESFC_CAL_STBY_BIT 1
`define ESFC_CAL_RST 32'h00000000
`define ESFC_CTRL_START_BIT 0
`define ESFC_CTRL_SRC_LSB 1
`define ESFC_CONV_NS 2000
`define ESFC_CLK_NS 10
`define ESFC_AC_HALF_NS 100
`endif

// [hw/esfc_pkg.sv]
// Purpose: Types for the external sensor front end control
// Assumes: Constants live in esfc_defs.svh
// Notes: Types only
package esfc_pkg;
  typedef enum logic [1:0] {
    ESFC_T1_LINEAR = 2'h0,
    ESFC_T1_FOLLOW = 2'h1,
    ESFC_T1_RSVD = 2'h2,
    ESFC_T1_AC = 2'h3
  } esfc_t1_e;
  typedef struct packed {
    logic [1:0] limit_sensor_select;
    logic use_preset;
    logic sensor_two_type;
    logic [1:0] sensor_one_type;
    logic [4:0] seti;
    logic [4:0] rang;
  } esfc_param_s;
  typedef struct packed {
    logic [4:0] current_tap;
    logic [4:0] ladder_tap;
    logic [1:0] mux_sel;
    logic vref_en;
    logic follower;
    logic autorange;
  } esfc_afe_s;
  typedef enum {ESFC_IDLE, ESFC_CONV} esfc_st_e;
endpackage

// [hw/esfc_top.sv]
// Purpose: Control logic for the external sensor front end: type decode, range, excitation pin
// Assumes: ADC and autorange analog outside; conversion time fixed by a counter
// Notes: Registers on APB; an idle start request runs two conversions for a bridge, else one if it names input one or two
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "esfc_defs.svh"

// Contract
// - Two-bit type one selects resistive, follower, AC
// - One-bit type two selects conductive or follower
// - Preset flag disables autorange, applies stored ranges
// - Five-bit range two picks ladder tap
// - Five-bit range one picks current source
// - Limit selector picks nth enabled logging sensor
// - Type 11 drives AC on excitation
// - Type 00, switch on, awake: battery during conversion
// - Type 00, switch off or standby: high impedance
// - Bridge converts input one then input two
// - AC mode samples input one, drives reference
// - AC square wave centred on reference, same amplitude
// - Types and selector written by setup command
module esfc_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] log_sensor_enable,
  output esfc_pkg::esfc_afe_s afe_ctrl,
  output logic [1:0] limit_index,
  output logic limit_valid,
  output logic excitation_out_o,
  output logic excitation_out_oe,
  output logic exc_ac_mode,
  output logic conv_busy,
  output logic conv_done
);
  import esfc_pkg::*;

  localparam int CONV_CYC_I = (`ESFC_CONV_NS + `ESFC_CLK_NS - 1) / `ESFC_CLK_NS;
  localparam logic [15:0] CONV_CYC = CONV_CYC_I[15:0];
  localparam int AC_HALF_I = `ESFC_AC_HALF_NS / `ESFC_CLK_NS;
  localparam logic [15:0] AC_HALF = AC_HALF_I[15:0];

  esfc_param_s param_q;
  logic sw_en_q;
  logic standby_q;
  esfc_st_e st_q;
  logic [15:0] cnt_q;
  logic second_q;
  logic [1:0] src_q;
  logic [15:0] ac_cnt_q;
  logic ac_phase_q;
  esfc_afe_s afe_q;
  logic exc_o_q;
  logic exc_oe_q;
  logic exc_ac_q;
  logic done_q;
  logic [31:0] prdata_q;
  logic wr_acc;
  logic rd_acc;
  logic start_req;
  logic bridge;
  logic [1:0] first_src;
  logic conv_end;
  logic [1:0] sel_pos;
  logic sel_found;
  logic [1:0] sel_idx;
  logic launch;
  logic next_pt;

  // APB answers in its access cycle, no wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign start_req = wr_acc && (paddr == `ESFC_OFF_CTRL) && pstrb[0]
    && pwdata[`ESFC_CTRL_START_BIT];

  // Setup parameter word; taken between conversions so the front end never glitches
  always_ff @(posedge mclk) begin
    if (srst) begin
      param_q <= esfc_param_s'(`ESFC_PARAM_RST);
    end else if (wr_acc && paddr == `ESFC_OFF_PARAM && st_q == ESFC_IDLE) begin
      param_q <= esfc_param_s'(pwdata[15:0]);
    end
  end

  // Calibration bits: supply switch and standby
  always_ff @(posedge mclk) begin
    if (srst) begin
      sw_en_q <= 1'b0;
      standby_q <= 1'b0;
    end else if (wr_acc && paddr == `ESFC_OFF_CAL && pstrb[0]) begin
      sw_en_q <= pwdata[`ESFC_CAL_SW_BIT];
      standby_q <= pwdata[`ESFC_CAL_STBY_BIT];
    end
  end

  // Bridge wiring is told by the types; host keeps it consistent
  assign bridge = (param_q.sensor_one_type == ESFC_T1_FOLLOW) && param_q.sensor_two_type;
  assign first_src = bridge ? 2'h1 : pwdata[`ESFC_CTRL_SRC_LSB +: 2];
  assign conv_end = (st_q == ESFC_CONV) && (cnt_q == CONV_CYC - 16'h0001);
  // Outside a bridge, a start that names no input launches nothing, so it must not touch the front end
  assign launch = (st_q == ESFC_IDLE) && start_req && (first_src == 2'h1 || first_src == 2'h2);
  assign next_pt = conv_end && bridge && !second_q;

  // Conversion sequencer; src 1 is input one, 2 is input two
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ESFC_IDLE;
      cnt_q <= 16'h0000;
      second_q <= 1'b0;
      src_q <= 2'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ESFC_IDLE: begin
          if (start_req && (first_src == 2'h1 || first_src == 2'h2)) begin
            st_q <= ESFC_CONV;
            cnt_q <= 16'h0000;
            src_q <= first_src;
            second_q <= 1'b0;
          end
        end
        ESFC_CONV: begin
          cnt_q <= cnt_q + 16'h0001;
          if (conv_end) begin
            cnt_q <= 16'h0000;
            if (bridge && !second_q) begin
              src_q <= 2'h2;
              second_q <= 1'b1;
            end else begin
              st_q <= ESFC_IDLE;
              done_q <= 1'b1;
            end
          end
        end
        default: st_q <= ESFC_IDLE;
      endcase
    end
  end

  // Front-end settings latched at each conversion start only; a lone conversion keeps
  // its settings past the end, so software reads back what the result was taken with
  always_ff @(posedge mclk) begin
    if (srst) begin
      afe_q <= '0;
    end else if (launch || next_pt) begin
      afe_q.current_tap <= param_q.seti;
      afe_q.ladder_tap <= param_q.rang;
      afe_q.autorange <= !param_q.use_preset;
      afe_q.vref_en <= (param_q.sensor_one_type == ESFC_T1_AC);
      if (param_q.sensor_one_type == ESFC_T1_AC) begin
        afe_q.mux_sel <= 2'h1;
        afe_q.follower <= 1'b0;
      end else if (next_pt || first_src == 2'h2) begin
        afe_q.mux_sel <= 2'h2;
        afe_q.follower <= param_q.sensor_two_type;
      end else begin
        afe_q.mux_sel <= 2'h1;
        afe_q.follower <= (param_q.sensor_one_type == ESFC_T1_FOLLOW);
      end
    end
  end

  // AC square wave timer; runs only while converting
  always_ff @(posedge mclk) begin
    if (srst || st_q != ESFC_CONV) begin
      ac_cnt_q <= 16'h0000;
      ac_phase_q <= 1'b0;
    end else if (ac_cnt_q == AC_HALF - 16'h0001) begin
      ac_cnt_q <= 16'h0000;
      ac_phase_q <= !ac_phase_q;
    end else begin
      ac_cnt_q <= ac_cnt_q + 16'h0001;
    end
  end

  // Excitation pin: levels around reference are done by the pad; here polarity and drive
  always_ff @(posedge mclk) begin
    if (srst) begin
      exc_o_q <= 1'b0;
      exc_oe_q <= 1'b0;
      exc_ac_q <= 1'b0;
    end else if (st_q == ESFC_CONV && param_q.sensor_one_type == ESFC_T1_AC) begin
      exc_oe_q <= 1'b1;
      exc_ac_q <= 1'b1;
      exc_o_q <= ac_phase_q;
    end else if (st_q == ESFC_CONV && param_q.sensor_one_type != ESFC_T1_RSVD
        && sw_en_q && !standby_q) begin
      exc_oe_q <= 1'b1;
      exc_ac_q <= 1'b0;
      exc_o_q <= 1'b1;
    end else begin
      exc_oe_q <= 1'b0;
      exc_ac_q <= 1'b0;
      exc_o_q <= 1'b0;
    end
  end

  // Limit check picks the nth set bit of the logging enables
  always_comb begin
    sel_pos = 2'h0;
    sel_found = 1'b0;
    sel_idx = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (!sel_found && log_sensor_enable[i]) begin
        if (sel_pos == param_q.limit_sensor_select) begin
          sel_found = 1'b1;
          sel_idx = i[1:0];
        end else begin
          sel_pos = sel_pos + 2'h1;
        end
      end
    end
  end

  logic [1:0] lim_idx_c;

  // Same search, index form, unrolled by a generate over entries
  logic [3:0] hit;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lim
      logic [2:0] below;
      always_comb begin
        below = 3'h0;
        for (int k = 0; k < g; k++) begin
          below = below + {2'h0, log_sensor_enable[k]};
        end
      end
      assign hit[g] = log_sensor_enable[g]
        && (below == {1'b0, param_q.limit_sensor_select});
    end
  endgenerate

  always_comb begin
    lim_idx_c = 2'h0;
    for (int j = 0; j < 4; j++) begin
      if (hit[j]) begin
        lim_idx_c = j[1:0];
      end
    end
  end

  // Registered limit index
  always_ff @(posedge mclk) begin
    if (srst) begin
      limit_index <= 2'h0;
      limit_valid <= 1'b0;
    end else begin
      limit_index <= lim_idx_c;
      limit_valid <= |hit;
    end
  end

  // Read data captured in setup so it stands through the access cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_q <= 32'h00000000;
    end else if (rd_acc) begin
      case (paddr)
        `ESFC_OFF_PARAM: prdata_q <= {16'h0000, param_q};
        `ESFC_OFF_CAL: prdata_q <= {30'h00000000, standby_q, sw_en_q};
        `ESFC_OFF_STATUS: prdata_q <= {26'h0000000, exc_ac_q, exc_oe_q, src_q, second_q,
          (st_q == ESFC_CONV)};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign afe_ctrl = afe_q;
  assign excitation_out_o = exc_o_q;
  assign excitation_out_oe = exc_oe_q;
  assign exc_ac_mode = exc_ac_q;
  assign conv_busy = (st_q == ESFC_CONV);
  assign conv_done = done_q;

  // Pin drive is registered off the state, so idle releases it one cycle later
  a_exc_idle: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ESFC_IDLE) |=> !exc_oe_q)
    else $error("excitation driven while idle");
  // Battery only while converting, switch on and awake
  a_bat: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ESFC_CONV && param_q.sensor_one_type == ESFC_T1_LINEAR && sw_en_q && !standby_q)
    |=> exc_oe_q && exc_o_q) else $error("battery not connected");
  // Switch off or standby keeps the resistive case floating
  a_hiz: assert property (@(posedge mclk) disable iff (srst)
    (param_q.sensor_one_type == ESFC_T1_LINEAR && (!sw_en_q || standby_q)) |=> !exc_oe_q)
    else $error("excitation not high impedance");
  // AC drive ignores the switch and standby bits
  a_ac: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ESFC_CONV && param_q.sensor_one_type == ESFC_T1_AC) |=> exc_oe_q && exc_ac_q)
    else $error("AC excitation missing");
  // Within a conversion the front end may only move at the point between two bridge conversions
  a_stable: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ESFC_CONV && !conv_end) |=> $stable(afe_q))
    else $error("front end changed mid conversion");
  // Bridge runs a second conversion on input two
  a_bridge: assert property (@(posedge mclk) disable iff (srst)
    (conv_end && bridge && !second_q) |=> src_q == 2'h2 && st_q == ESFC_CONV)
    else $error("bridge second conversion missing");
  // Second bridge point really senses input two unless the AC case forces input one
  a_second_mux: assert property (@(posedge mclk) disable iff (srst)
    (conv_busy && second_q && !afe_q.vref_en) |-> afe_q.mux_sel == 2'h2)
    else $error("second conversion not on input two");
  // Preset turns autorange off for the conversion that follows
  a_preset: assert property (@(posedge mclk) disable iff (srst)
    (launch && param_q.use_preset) |=> !afe_q.autorange)
    else $error("autorange left on with preset");
  // Start edge, 200 counted cycles, then the registered done pulse
  a_done: assert property (@(posedge mclk) disable iff (srst)
    (launch && !bridge) |-> ##201 conv_done)
    else $error("single conversion length wrong");
  // Done is a single-cycle pulse
  a_done_once: assert property (@(posedge mclk) disable iff (srst)
    conv_done |=> !conv_done)
    else $error("done held longer than one cycle");
  // AC mode always senses input one and enables the reference
  a_ac_src: assert property (@(posedge mclk) disable iff (srst)
    afe_q.vref_en |-> afe_q.mux_sel == 2'h1)
    else $error("AC mode not on input one");
  // Two independent searches for the nth enabled sensor must agree
  a_lim_valid: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> limit_valid == $past(sel_found))
    else $error("limit valid disagrees with search");
  a_lim_idx: assert property (@(posedge mclk) disable iff (srst)
    sel_found |=> limit_index == $past(sel_idx))
    else $error("limit index disagrees with search");
endmodule // esfc_top

// [dv/esfc_sensor_model.sv]
// Purpose: Far side of the excitation pad, resolving the wire and counting AC edges
// Assumes: Pad floats with no pull when released
// Notes: Behavioural
`timescale 1ns/1ps
module esfc_sensor_model (
  input wire logic mclk,
  input wire logic clr,
  input wire logic excitation_out_o,
  input wire logic excitation_out_oe,
  output logic exc_wire,
  output int ac_edges
);
  logic last_q;
  logic oe_q;
  // Released pad shows the inverse of the last level, so a stale value never passes
  assign exc_wire = excitation_out_oe ? excitation_out_o : ~last_q;
  // Edge count while driven shows the square wave; the drive's own first cycle is no edge
  always_ff @(posedge mclk) begin
    oe_q <= excitation_out_oe;
    if (clr) begin
      last_q <= 1'b0;
      ac_edges <= 0;
    end else begin
      last_q <= exc_wire;
      if (excitation_out_oe && oe_q && exc_wire !== last_q) ac_edges <= ac_edges + 1;
    end
  end
endmodule // esfc_sensor_model

// [dv/test_external_sensor_frontend_control.sv]
// Purpose: Self-checking bench for the front end control
// Assumes: Zero-wait APB slave, fixed conversion length
// Notes: Table rows first, bridge and refusals after
`timescale 1ns/1ps
`include "esfc_defs.svh"
module test_external_sensor_frontend_control;
  import esfc_pkg::*;
  typedef struct packed {
    logic [1:0] t1; logic t2, pre, sw, stby; logic [3:0] en; logic [1:0] ls, src; logic oe, ac;
  } esfc_row_s;
  localparam int CONV = `ESFC_CONV_NS / `ESFC_CLK_NS;
  logic mclk, srst, psel, penable, pwrite, clr, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb, log_sensor_enable;
  esfc_afe_s afe_ctrl, snap;
  logic [1:0] limit_index;
  logic limit_valid, excitation_out_o, excitation_out_oe, exc_ac_mode, conv_busy, conv_done;
  logic exc_wire;
  int ac_edges, mismatches, checks_done, cyc, moved;
  esfc_row_s rows [7];
  esfc_param_s p;
  esfc_top u_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .log_sensor_enable(log_sensor_enable), .afe_ctrl(afe_ctrl),
    .limit_index(limit_index), .limit_valid(limit_valid), .excitation_out_o(excitation_out_o),
    .excitation_out_oe(excitation_out_oe), .exc_ac_mode(exc_ac_mode), .conv_busy(conv_busy),
    .conv_done(conv_done));
  esfc_sensor_model u_sensor (.mclk(mclk), .clr(clr), .excitation_out_o(excitation_out_o),
    .excitation_out_oe(excitation_out_oe), .exc_wire(exc_wire), .ac_edges(ac_edges));
  // Clock
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, generous against the few thousand cycles needed
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high in the access phase
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hF;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask
  // Nth enabled sensor as {valid, index}
  function automatic logic [2:0] nth(input logic [3:0] en, input logic [1:0] s);
    int c;
    c = 0;
    nth = 3'h0;
    for (int k = 0; k < 4; k++) if (en[k]) begin
      if (c == s) nth = {1'b1, 2'(k)};
      c++;
    end
  endfunction
  // Bounded wait for busy, then watch the conversion until done
  task automatic run(input int n);
    for (int i = 0; i < 20 && conv_busy !== 1'b1; i++) @(negedge mclk);
    repeat (3) @(negedge mclk);
    snap = afe_ctrl;
    moved = 0;
    for (int i = 0; i < n && conv_done !== 1'b1; i++) begin
      @(negedge mclk);
      if (conv_busy === 1'b1 && afe_ctrl !== snap) moved++;
    end
  endtask
  initial begin
    {srst, psel, penable, pwrite, clr} = 5'h11;
    {paddr, pwdata, pstrb, log_sensor_enable} = 0;
    {mismatches, checks_done, cyc} = 0;
    rows[0] = '{2'h0, 0, 1, 1, 0, 4'hF, 2'h0, 2'h1, 1, 0};
    rows[1] = '{2'h0, 0, 0, 0, 0, 4'h5, 2'h1, 2'h2, 0, 0};
    rows[2] = '{2'h0, 0, 1, 1, 1, 4'hA, 2'h1, 2'h1, 0, 0};
    rows[3] = '{2'h0, 0, 0, 0, 1, 4'h8, 2'h0, 2'h1, 0, 0};
    rows[4] = '{2'h3, 0, 1, 0, 1, 4'h6, 2'h2, 2'h1, 1, 1};
    rows[5] = '{2'h2, 1, 1, 1, 0, 4'hF, 2'h3, 2'h1, 0, 0};
    rows[6] = '{2'h1, 0, 1, 1, 0, 4'h3, 2'h1, 2'h1, 1, 0};
    repeat (6) @(posedge mclk);
    srst <= 0;
    @(negedge mclk);
    chk({afe_ctrl, excitation_out_oe, conv_busy, limit_valid}, 0);
    apb(0, `ESFC_OFF_PARAM, 0);
    chk(r, `ESFC_PARAM_RST);
    apb(0, `ESFC_OFF_CAL, 0);
    chk(r, `ESFC_CAL_RST);
    foreach (rows[i]) begin
      p = '{rows[i].ls, rows[i].pre, rows[i].t2, rows[i].t1, 5'(i * 3 + 1), 5'(31 - i * 4)};
      log_sensor_enable <= rows[i].en;
      apb(1, `ESFC_OFF_CAL, {30'h0, rows[i].stby, rows[i].sw});
      apb(1, `ESFC_OFF_PARAM, {16'h0, p});
      clr <= 1;
      apb(1, `ESFC_OFF_CTRL, {29'h0, rows[i].src, 1'b1});
      clr <= 0;
      chk({limit_valid, limit_index}, nth(rows[i].en, rows[i].ls));
      run(CONV + 20);
      chk(excitation_out_oe, rows[i].oe);
      chk(exc_ac_mode, rows[i].ac);
      chk(afe_ctrl.vref_en, rows[i].ac);
      chk(afe_ctrl.autorange, !rows[i].pre);
      if (rows[i].pre) chk({afe_ctrl.current_tap, afe_ctrl.ladder_tap}, {p.seti, p.rang});
      chk(afe_ctrl.follower, rows[i].src == 2'h1 ? rows[i].t1 == 2'h1 : rows[i].t2);
      if (rows[i].oe && !rows[i].ac) chk(exc_wire, 1);
      chk(moved, 0);
      chk(conv_done, 1);
      if (rows[i].ac) chk(ac_edges > 10, 1);
      else chk(ac_edges, 0);
      repeat (3) @(negedge mclk);
      chk(excitation_out_oe, 0);
    end
    // Bridge: types 01 and 1, both sensors logged, start names input two
    log_sensor_enable <= 4'h6;
    apb(1, `ESFC_OFF_CAL, 32'h1);
    apb(1, `ESFC_OFF_PARAM, 32'h1400 | 32'h0400);
    apb(1, `ESFC_OFF_CTRL, 32'h5);
    apb(0, `ESFC_OFF_STATUS, 0);
    chk({r[3:0]}, 4'h5);
    apb(1, `ESFC_OFF_PARAM, 32'h0); // write while busy must be dropped
    repeat (CONV) @(negedge mclk);
    apb(0, `ESFC_OFF_STATUS, 0);
    chk({r[3:0]}, 4'hB);
    run(2 * CONV);
    chk(conv_done, 1);
    apb(0, `ESFC_OFF_PARAM, 0);
    chk(r[15:0], 16'h1400);
    // Start naming no input is refused; unmapped read answers without error
    apb(1, `ESFC_OFF_PARAM, 32'h0);
    apb(1, `ESFC_OFF_CTRL, 32'h1);
    repeat (5) @(negedge mclk);
    chk(conv_busy, 0);
    apb(0, 12'h010, 0);
    chk(pslverr, 0);
    finish_test();
  end
endmodule // test_external_sensor_frontend_control
